// ### design/ptc_pkg.sv
// package: command codes, defaults and formats of the telemetry command bank
package ptc_pkg;
	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_VOUT_RD    = 8'h8b;
	localparam logic [7:0] CMD_IOUT_RD    = 8'h8c;
	localparam logic [7:0] CMD_TEXT_RD    = 8'h8d;
	localparam logic [7:0] CMD_TDIE_RD    = 8'h8e;
	localparam logic [7:0] CMD_FREQ_RD    = 8'h95;
	localparam logic [7:0] CMD_POUT_RD    = 8'h96;
	localparam logic [7:0] CMD_PIN_RD     = 8'h97;
	localparam logic [7:0] CMD_PROTO_REV  = 8'h98;
	localparam logic [7:0] CMD_VOUT_CEIL  = 8'ha5;
	localparam logic [7:0] CMD_PIN_ACC    = 8'hac;
	localparam logic [7:0] CMD_OEM0       = 8'hb0;
	localparam logic [7:0] CMD_TOOLW      = 8'hb1;
	localparam logic [7:0] CMD_OEM2       = 8'hb2;
	localparam logic [7:0] CMD_USER_PG    = 8'hb3;
	localparam logic [7:0] CMD_USER_GL    = 8'hb4;
	localparam logic [7:0] CMD_MFG_INFO   = 8'hb6;
	localparam logic [7:0] CMD_CHAN_CFG   = 8'hd0;
	localparam logic [7:0] CMD_GLOB_CFG   = 8'hd1;
	localparam logic [7:0] CMD_FLT_ROUTE  = 8'hd2;
	localparam logic [7:0] CMD_LOOP_COMP  = 8'hd3;
	localparam logic [7:0] CMD_MOD_CFG    = 8'hd4;
	localparam logic [7:0] CMD_EXT_FLT    = 8'hd5;
	localparam logic [7:0] CMD_OT_ACT     = 8'hd6;
	localparam logic [7:0] CMD_IOUT_PK    = 8'hd7;
	localparam logic [7:0] CMD_ADC_SEL    = 8'hd8;
	localparam logic [7:0] CMD_RETRY      = 8'hdb;
	localparam logic [7:0] CMD_RESTART    = 8'hdc;
	localparam logic [7:0] CMD_VOUT_PK    = 8'hdd;
	localparam logic [7:0] CMD_VIN_PK     = 8'hde;
	localparam logic [7:0] CMD_TEXT_PK    = 8'hdf;
	localparam logic [7:0] CMD_IIN_PK     = 8'he1;
	localparam logic [7:0] CMD_PEAK_CLR   = 8'he3;
	localparam logic [7:0] CMD_ICHIP      = 8'he4;
	localparam logic [7:0] CMD_PADS       = 8'he5;
	localparam logic [7:0] CMD_BUS_ADDR   = 8'he6;
	localparam logic [7:0] CMD_REV_CODE   = 8'he7;
	localparam logic [7:0] CMD_SENSE_RES  = 8'he8;
	localparam logic [7:0] CMD_STORE_ALL  = 8'h15;
	localparam logic [7:0] CMD_RESTR_ALL  = 8'h16;
	// ----------------------------------------------------------------
	// defaults and fixed values
	// ----------------------------------------------------------------
	localparam logic [7:0]  PROTO_REV_VAL = 8'h22;
	localparam logic [15:0] VOUT_CEIL_VAL = 16'h5b33;
	localparam logic [7:0]  PIN_ACC_VAL   = 8'h05;
	localparam logic [7:0]  OT_ACT_VAL    = 8'hc0;
	localparam logic [15:0] USER_DEF      = 16'h0000;
	localparam logic [7:0]  CHAN_CFG_DEF  = 8'h1d;
	localparam logic [7:0]  GLOB_CFG_DEF  = 8'h21;
	localparam logic [15:0] FLT_ROUTE_DEF = 16'h6993;
	localparam logic [7:0]  LOOP_COMP_DEF = 8'hae;
	localparam logic [7:0]  MOD_CFG_DEF   = 8'hc7;
	localparam logic [7:0]  EXT_FLT_DEF   = 8'hc0;
	localparam logic [7:0]  ADC_SEL_DEF   = 8'h00;
	localparam logic [15:0] RETRY_DEF     = 16'hfabc;
	localparam logic [15:0] RESTART_DEF   = 16'hfbe8;
	localparam logic [6:0]  BUS_ADDR_DEF  = 7'h4f;
	localparam logic [15:0] SENSE_RES_DEF = 16'hca80;
	// ----------------------------------------------------------------
	// linear formats
	// ----------------------------------------------------------------
	localparam int EXP_MSB  = 15;
	localparam int EXP_LSB  = 11;
	localparam int MANT_MSB = 10;
	localparam int L16_EXP  = -12;
	localparam int CLK_MHZ  = 200;
	localparam int MS_CYC   = CLK_MHZ * 1000;
endpackage : ptc_pkg

// ### design/ptc_bank.sv
// command register bank of a dual-channel power controller
//
// Summary of operation
// R1 - paged read-only output-voltage peak, largest value since last clear
// R2 - non-paged read-only input-voltage peak since last clear
// R3 - read-only peaks: external temperature paged, input current global
// R4 - paged read-only output-current peak since last clear
// R5 - send-byte peak-clear command with no data resets all peaks
// R6 - external temperature reading is the only temperature used inside
// R7 - die temperature word reported only, influences nothing else
// R8 - protocol revision byte reads fixed value for revision 1.2
// R9 - 7-bit bus address byte, non-volatile, defaults to 0x4f
// R10 - paged fault routing word, default 0x6993, gates shared fault pin
// R11 - paged action byte, default 0xc0, taken when fault pin pulled low
// R12 - run pin held low at least paged restart time, default 500 ms
// R13 - in retry mode wait paged retry interval, default 350 ms
// R14 - global volatile byte selects parameter for fast conversion
// R15 - non-paged read-only output ceiling word reads 0x5b33
// R16 - read-only byte gives input power accuracy, five percent
// R17 - paged and global user words, default zero, non-volatile
// R18 - paged switching frequency word in linear eleven format
// R19 - global sense resistance word, default 0xca80, non-volatile
// R20 - paged loop compensation 0xae and modulator config 0xc7, stored
// R21 - linear eleven: 5-bit exponent top, 11-bit mantissa below
// R22 - linear sixteen: unsigned mantissa, fixed exponent minus twelve
// R23 - non-volatile commands saved by store-all, reloaded by restore-all
// R24 - peak rises on larger sample; first sample after clear starts it
// R25 - paged commands keep one copy per channel, chosen by page
`timescale 1ns/1ps

module ptc_bank #(
	parameter int CHANNELS = 2
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// command port
	input  wire logic        cmd_valid_i,
	input  wire logic        cmd_write_i,
	input  wire logic [7:0]  cmd_code_i,
	input  wire logic [15:0] cmd_wdata_i,
	input  wire logic        cmd_page_i,
	output logic [15:0]      cmd_rdata_o,
	output logic             cmd_ack_o,
	output logic             cmd_err_o,
	// telemetry samples, strobed per channel and globally
	input  wire logic [1:0]  meas_valid_i,
	input  wire logic [31:0] meas_vout_i,
	input  wire logic [31:0] meas_iout_i,
	input  wire logic [31:0] meas_text_i,
	input  wire logic [31:0] meas_freq_i,
	input  wire logic [31:0] meas_pout_i,
	input  wire logic [31:0] meas_pin_i,
	input  wire logic        meas_gvalid_i,
	input  wire logic [15:0] meas_vin_i,
	input  wire logic [15:0] meas_iin_i,
	input  wire logic [15:0] meas_tdie_i,
	// fault pin, open drain
	input  wire logic        fault_pin_i,
	input  wire logic [15:0] fault_src_i,
	output logic             fault_pin_o,
	output logic             fault_pin_oe_o,
	// run pins, open drain, per channel
	output logic [1:0]       run_pin_o,
	output logic [1:0]       run_pin_oe_o,
	input  wire logic [1:0]  restart_req_i,
	input  wire logic [1:0]  retry_mode_i,
	output logic [1:0]       retry_go_o,
	// configuration seen by the regulator
	output logic [7:0]       ext_fault_action_o,
	output logic             ext_fault_seen_o,
	output logic [7:0]       fast_adc_select_o,
	output logic [6:0]       bus_address_o,
	output logic [15:0]      temp_for_gain_o,
	// non-volatile store
	output logic             nvm_busy_o
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	localparam int NCH = CHANNELS;
	logic [15:0] user_pg   [NCH];
	logic [15:0] flt_route [NCH];
	logic [7:0]  loop_comp [NCH];
	logic [7:0]  mod_cfg   [NCH];
	logic [7:0]  chan_cfg  [NCH];
	logic [7:0]  ext_flt   [NCH];
	logic [15:0] retry_iv  [NCH];
	logic [15:0] restart_t [NCH];
	logic [15:0] tool_w    [NCH];
	logic [15:0] user_gl;
	logic [15:0] oem0;
	logic [15:0] oem2;
	logic [7:0]  glob_cfg;
	logic [7:0]  adc_sel;
	logic [6:0]  bus_addr;
	logic [15:0] sense_res;
	// shadow copies that stand in for the non-volatile array
	logic [15:0] nv_user_pg [NCH];
	logic [15:0] nv_route   [NCH];
	logic [7:0]  nv_comp    [NCH];
	logic [7:0]  nv_mod     [NCH];
	logic [7:0]  nv_chan    [NCH];
	logic [7:0]  nv_ext     [NCH];
	logic [15:0] nv_retry   [NCH];
	logic [15:0] nv_restart [NCH];
	logic [15:0] nv_user_gl;
	logic [7:0]  nv_glob;
	logic [6:0]  nv_addr;
	logic [15:0] nv_sense;
	// telemetry
	logic [15:0] vout_rd [NCH];
	logic [15:0] iout_rd [NCH];
	logic [15:0] text_rd [NCH];
	logic [15:0] freq_rd [NCH];
	logic [15:0] pout_rd [NCH];
	logic [15:0] pin_rd  [NCH];
	logic [15:0] vin_rd;
	logic [15:0] iin_rd;
	logic [15:0] tdie_rd;
	logic [15:0] vout_pk [NCH];
	logic [15:0] iout_pk [NCH];
	logic [15:0] text_pk [NCH];
	logic [15:0] vin_pk;
	logic [15:0] iin_pk;
	logic [NCH-1:0] pk_fresh;
	logic        g_fresh;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// linear eleven value to a signed value scaled by 2^16
	function automatic logic signed [47:0] l11_val(input logic [15:0] w);
		logic signed [4:0]  e;
		logic signed [47:0] m;
		e = signed'(w[ptc_pkg::EXP_MSB:ptc_pkg::EXP_LSB]); // [R21]
		m = 48'(signed'(w[ptc_pkg::MANT_MSB:0])) <<< 16;
		l11_val = (e < 0) ? (m >>> (-e)) : (m <<< e);
	endfunction : l11_val

	// linear eleven millisecond word to clock cycles
	function automatic logic [39:0] l11_ms_cyc(input logic [15:0] w);
		logic signed [47:0] v;
		v = l11_val(w);
		if (v <= 0)
			l11_ms_cyc = 40'd1;
		else
			l11_ms_cyc = 40'((v * ptc_pkg::MS_CYC) >>> 16) + 40'd1;
	endfunction : l11_ms_cyc

	// is the new sample larger (linear eleven, signed)
	function automatic logic l11_gt(input logic [15:0] a,
	                                input logic [15:0] b);
		l11_gt = l11_val(a) > l11_val(b);
	endfunction : l11_gt

	wire logic cmd_wr = cmd_valid_i && cmd_write_i;
	wire logic pg     = cmd_page_i;
	wire logic do_clr = cmd_wr && cmd_code_i == ptc_pkg::CMD_PEAK_CLR;
	wire logic do_sto = cmd_wr && cmd_code_i == ptc_pkg::CMD_STORE_ALL;
	wire logic do_rst = cmd_wr && cmd_code_i == ptc_pkg::CMD_RESTR_ALL;

	// ----------------------------------------------------------------
	// telemetry capture and peaks
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (reset_i) begin
				vout_rd[c] <= '0;
				iout_rd[c] <= '0;
				text_rd[c] <= '0;
				freq_rd[c] <= '0;
				pout_rd[c] <= '0;
				pin_rd[c]  <= '0;
				vout_pk[c] <= '0;
				iout_pk[c] <= '0;
				text_pk[c] <= '0;
				pk_fresh[c] <= 1'b1;
			end else if (meas_valid_i[c]) begin
				vout_rd[c] <= meas_vout_i[16*c +: 16]; // [R22]
				iout_rd[c] <= meas_iout_i[16*c +: 16];
				text_rd[c] <= meas_text_i[16*c +: 16];
				freq_rd[c] <= meas_freq_i[16*c +: 16]; // [R18]
				pout_rd[c] <= meas_pout_i[16*c +: 16];
				pin_rd[c]  <= meas_pin_i[16*c +: 16];
				// unsigned compare for linear sixteen
				if (pk_fresh[c] || meas_vout_i[16*c +: 16] > vout_pk[c])
					vout_pk[c] <= meas_vout_i[16*c +: 16]; // [R1] [R24]
				if (pk_fresh[c] || l11_gt(meas_iout_i[16*c +: 16],
				                          iout_pk[c]))
					iout_pk[c] <= meas_iout_i[16*c +: 16]; // [R4] [R24]
				if (pk_fresh[c] || l11_gt(meas_text_i[16*c +: 16],
				                          text_pk[c]))
					text_pk[c] <= meas_text_i[16*c +: 16]; // [R3] [R24]
				// a clear landing with a sample restarts from the next sample
				pk_fresh[c] <= do_clr; // [R5]
			end else if (do_clr) begin
				pk_fresh[c] <= 1'b1; // [R5]
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			vin_rd  <= '0;
			iin_rd  <= '0;
			tdie_rd <= '0;
			vin_pk  <= '0;
			iin_pk  <= '0;
			g_fresh <= 1'b1;
		end else if (meas_gvalid_i) begin
			vin_rd  <= meas_vin_i;
			iin_rd  <= meas_iin_i;
			tdie_rd <= meas_tdie_i; // [R7]
			if (g_fresh || l11_gt(meas_vin_i, vin_pk))
				vin_pk <= meas_vin_i; // [R2] [R24]
			if (g_fresh || l11_gt(meas_iin_i, iin_pk))
				iin_pk <= meas_iin_i; // [R3] [R24]
			g_fresh <= do_clr;
		end else if (do_clr) begin
			g_fresh <= 1'b1; // [R5]
		end
	end

	// ----------------------------------------------------------------
	// writable configuration and store / restore
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int c = 0; c < NCH; c++) begin
				user_pg[c]   <= ptc_pkg::USER_DEF;
				flt_route[c] <= ptc_pkg::FLT_ROUTE_DEF;
				loop_comp[c] <= ptc_pkg::LOOP_COMP_DEF;
				mod_cfg[c]   <= ptc_pkg::MOD_CFG_DEF;
				chan_cfg[c]  <= ptc_pkg::CHAN_CFG_DEF;
				ext_flt[c]   <= ptc_pkg::EXT_FLT_DEF;
				retry_iv[c]  <= ptc_pkg::RETRY_DEF;
				restart_t[c] <= ptc_pkg::RESTART_DEF;
				tool_w[c]    <= ptc_pkg::USER_DEF;
			end
			user_gl   <= ptc_pkg::USER_DEF;
			oem0      <= ptc_pkg::USER_DEF;
			oem2      <= ptc_pkg::USER_DEF;
			glob_cfg  <= ptc_pkg::GLOB_CFG_DEF;
			adc_sel   <= ptc_pkg::ADC_SEL_DEF;
			bus_addr  <= ptc_pkg::BUS_ADDR_DEF;
			sense_res <= ptc_pkg::SENSE_RES_DEF;
		end else if (do_rst) begin
			user_pg   <= nv_user_pg; // [R23]
			flt_route <= nv_route;
			loop_comp <= nv_comp;
			mod_cfg   <= nv_mod;
			chan_cfg  <= nv_chan;
			ext_flt   <= nv_ext;
			retry_iv  <= nv_retry;
			restart_t <= nv_restart;
			user_gl   <= nv_user_gl;
			glob_cfg  <= nv_glob;
			bus_addr  <= nv_addr;
			sense_res <= nv_sense;
		end else if (cmd_wr) begin
			case (cmd_code_i) // [R25]
				ptc_pkg::CMD_USER_PG:   user_pg[pg]   <= cmd_wdata_i; // [R17]
				ptc_pkg::CMD_USER_GL:   user_gl       <= cmd_wdata_i; // [R17]
				ptc_pkg::CMD_OEM0:      oem0          <= cmd_wdata_i;
				ptc_pkg::CMD_OEM2:      oem2          <= cmd_wdata_i;
				ptc_pkg::CMD_TOOLW:     tool_w[pg]    <= cmd_wdata_i;
				ptc_pkg::CMD_FLT_ROUTE: flt_route[pg] <= cmd_wdata_i; // [R10]
				ptc_pkg::CMD_LOOP_COMP: loop_comp[pg] <= cmd_wdata_i[7:0]; // [R20]
				ptc_pkg::CMD_MOD_CFG:   mod_cfg[pg]   <= cmd_wdata_i[7:0]; // [R20]
				ptc_pkg::CMD_CHAN_CFG:  chan_cfg[pg]  <= cmd_wdata_i[7:0];
				ptc_pkg::CMD_EXT_FLT:   ext_flt[pg]   <= cmd_wdata_i[7:0]; // [R11]
				ptc_pkg::CMD_RETRY:     retry_iv[pg]  <= cmd_wdata_i; // [R13]
				ptc_pkg::CMD_RESTART:   restart_t[pg] <= cmd_wdata_i; // [R12]
				ptc_pkg::CMD_GLOB_CFG:  glob_cfg      <= cmd_wdata_i[7:0];
				ptc_pkg::CMD_ADC_SEL:   adc_sel       <= cmd_wdata_i[7:0]; // [R14]
				ptc_pkg::CMD_BUS_ADDR:  bus_addr      <= cmd_wdata_i[6:0]; // [R9]
				ptc_pkg::CMD_SENSE_RES: sense_res     <= cmd_wdata_i; // [R19]
				default: ;
			endcase
		end
	end

	// adc select is volatile, so it is absent from the store set
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			for (int c = 0; c < NCH; c++) begin
				nv_user_pg[c] <= ptc_pkg::USER_DEF;
				nv_route[c]   <= ptc_pkg::FLT_ROUTE_DEF;
				nv_comp[c]    <= ptc_pkg::LOOP_COMP_DEF;
				nv_mod[c]     <= ptc_pkg::MOD_CFG_DEF;
				nv_chan[c]    <= ptc_pkg::CHAN_CFG_DEF;
				nv_ext[c]     <= ptc_pkg::EXT_FLT_DEF;
				nv_retry[c]   <= ptc_pkg::RETRY_DEF;
				nv_restart[c] <= ptc_pkg::RESTART_DEF;
			end
			nv_user_gl <= ptc_pkg::USER_DEF;
			nv_glob    <= ptc_pkg::GLOB_CFG_DEF;
			nv_addr    <= ptc_pkg::BUS_ADDR_DEF;
			nv_sense   <= ptc_pkg::SENSE_RES_DEF;
		end else if (do_sto) begin
			nv_user_pg <= user_pg; // [R23]
			nv_route   <= flt_route;
			nv_comp    <= loop_comp;
			nv_mod     <= mod_cfg;
			nv_chan    <= chan_cfg;
			nv_ext     <= ext_flt;
			nv_retry   <= retry_iv;
			nv_restart <= restart_t;
			nv_user_gl <= user_gl;
			nv_glob    <= glob_cfg;
			nv_addr    <= bus_addr;
			nv_sense   <= sense_res;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	logic [15:0] rd_mux;
	logic        rd_bad;
	always_comb begin
		rd_bad = 1'b0;
		case (cmd_code_i)
			ptc_pkg::CMD_VOUT_RD:   rd_mux = vout_rd[pg];
			ptc_pkg::CMD_IOUT_RD:   rd_mux = iout_rd[pg];
			ptc_pkg::CMD_TEXT_RD:   rd_mux = text_rd[pg]; // [R6]
			ptc_pkg::CMD_TDIE_RD:   rd_mux = tdie_rd; // [R7]
			ptc_pkg::CMD_FREQ_RD:   rd_mux = freq_rd[pg]; // [R18]
			ptc_pkg::CMD_POUT_RD:   rd_mux = pout_rd[pg];
			ptc_pkg::CMD_PIN_RD:    rd_mux = pin_rd[pg];
			ptc_pkg::CMD_PROTO_REV: rd_mux = {8'h00, ptc_pkg::PROTO_REV_VAL}; // [R8]
			ptc_pkg::CMD_VOUT_CEIL: rd_mux = ptc_pkg::VOUT_CEIL_VAL; // [R15]
			ptc_pkg::CMD_PIN_ACC:   rd_mux = {8'h00, ptc_pkg::PIN_ACC_VAL}; // [R16]
			ptc_pkg::CMD_OEM0:      rd_mux = oem0;
			ptc_pkg::CMD_TOOLW:     rd_mux = tool_w[pg];
			ptc_pkg::CMD_OEM2:      rd_mux = oem2;
			ptc_pkg::CMD_USER_PG:   rd_mux = user_pg[pg]; // [R17]
			ptc_pkg::CMD_USER_GL:   rd_mux = user_gl; // [R17]
			ptc_pkg::CMD_CHAN_CFG:  rd_mux = {8'h00, chan_cfg[pg]};
			ptc_pkg::CMD_GLOB_CFG:  rd_mux = {8'h00, glob_cfg};
			ptc_pkg::CMD_FLT_ROUTE: rd_mux = flt_route[pg];
			ptc_pkg::CMD_LOOP_COMP: rd_mux = {8'h00, loop_comp[pg]};
			ptc_pkg::CMD_MOD_CFG:   rd_mux = {8'h00, mod_cfg[pg]};
			ptc_pkg::CMD_EXT_FLT:   rd_mux = {8'h00, ext_flt[pg]};
			ptc_pkg::CMD_OT_ACT:    rd_mux = {8'h00, ptc_pkg::OT_ACT_VAL};
			ptc_pkg::CMD_IOUT_PK:   rd_mux = iout_pk[pg]; // [R4]
			ptc_pkg::CMD_ADC_SEL:   rd_mux = {8'h00, adc_sel};
			ptc_pkg::CMD_RETRY:     rd_mux = retry_iv[pg];
			ptc_pkg::CMD_RESTART:   rd_mux = restart_t[pg];
			ptc_pkg::CMD_VOUT_PK:   rd_mux = vout_pk[pg]; // [R1]
			ptc_pkg::CMD_VIN_PK:    rd_mux = vin_pk; // [R2]
			ptc_pkg::CMD_TEXT_PK:   rd_mux = text_pk[pg]; // [R3]
			ptc_pkg::CMD_IIN_PK:    rd_mux = iin_pk; // [R3]
			ptc_pkg::CMD_BUS_ADDR:  rd_mux = {9'h000, bus_addr}; // [R9]
			ptc_pkg::CMD_SENSE_RES: rd_mux = sense_res; // [R19]
			default: begin
				rd_mux = 16'h0000;
				rd_bad = 1'b1;
			end
		endcase
	end

	// writes to read-only or unknown codes are flagged, data dropped
	logic wr_ok;
	always_comb begin
		case (cmd_code_i)
			ptc_pkg::CMD_OEM0, ptc_pkg::CMD_TOOLW, ptc_pkg::CMD_OEM2,
			ptc_pkg::CMD_USER_PG, ptc_pkg::CMD_USER_GL,
			ptc_pkg::CMD_CHAN_CFG, ptc_pkg::CMD_GLOB_CFG,
			ptc_pkg::CMD_FLT_ROUTE, ptc_pkg::CMD_LOOP_COMP,
			ptc_pkg::CMD_MOD_CFG, ptc_pkg::CMD_EXT_FLT,
			ptc_pkg::CMD_ADC_SEL, ptc_pkg::CMD_RETRY,
			ptc_pkg::CMD_RESTART, ptc_pkg::CMD_BUS_ADDR,
			ptc_pkg::CMD_SENSE_RES, ptc_pkg::CMD_PEAK_CLR,
			ptc_pkg::CMD_STORE_ALL, ptc_pkg::CMD_RESTR_ALL: wr_ok = 1'b1;
			default: wr_ok = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cmd_rdata_o <= '0;
			cmd_ack_o   <= 1'b0;
			cmd_err_o   <= 1'b0;
			nvm_busy_o  <= 1'b0;
		end else begin
			cmd_ack_o   <= cmd_valid_i;
			cmd_err_o   <= cmd_valid_i && (cmd_write_i ? !wr_ok : rd_bad);
			cmd_rdata_o <= (cmd_valid_i && !cmd_write_i) ? rd_mux : 16'h0000;
			nvm_busy_o  <= do_sto;
		end
	end

	// ----------------------------------------------------------------
	// fault pin, run pins and retry timing
	// ----------------------------------------------------------------
	logic [NCH-1:0] flt_hit;
	always_comb begin
		for (int c = 0; c < NCH; c++)
			flt_hit[c] = |(fault_src_i & flt_route[c]); // [R10]
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			fault_pin_o        <= 1'b0;
			fault_pin_oe_o     <= 1'b1;
			ext_fault_seen_o   <= 1'b0;
			ext_fault_action_o <= ptc_pkg::EXT_FLT_DEF;
			fast_adc_select_o  <= ptc_pkg::ADC_SEL_DEF;
			bus_address_o      <= ptc_pkg::BUS_ADDR_DEF;
			temp_for_gain_o    <= '0;
		end else begin
			fault_pin_o    <= 1'b0;
			// enable low while pulling the pin down
			fault_pin_oe_o <= !(|flt_hit); // [R10]
			// only external pull counts: own drive is excluded
			ext_fault_seen_o <= !fault_pin_i && fault_pin_oe_o; // [R11]
			ext_fault_action_o <= ext_flt[pg]; // [R11]
			fast_adc_select_o  <= adc_sel; // [R14]
			bus_address_o      <= bus_addr; // [R9]
			temp_for_gain_o    <= text_rd[pg]; // [R6]
		end
	end

	logic [39:0] hold_cnt  [NCH];
	logic [39:0] retry_cnt [NCH];
	always_ff @(posedge ref_clk_i) begin
		for (int c = 0; c < NCH; c++) begin
			if (reset_i) begin
				hold_cnt[c]     <= '0;
				retry_cnt[c]    <= '0;
				run_pin_o[c]    <= 1'b0;
				run_pin_oe_o[c] <= 1'b1;
				retry_go_o[c]   <= 1'b0;
			end else begin
				run_pin_o[c] <= 1'b0;
				if (restart_req_i[c])
					hold_cnt[c] <= l11_ms_cyc(restart_t[c]); // [R12]
				else if (hold_cnt[c] != '0)
					hold_cnt[c] <= hold_cnt[c] - 40'd1;
				run_pin_oe_o[c] <= !(restart_req_i[c] ||
				                     hold_cnt[c] > 40'd1); // [R12]
				retry_go_o[c] <= 1'b0;
				if (!retry_mode_i[c])
					retry_cnt[c] <= l11_ms_cyc(retry_iv[c]); // [R13]
				else if (retry_cnt[c] > 40'd1)
					retry_cnt[c] <= retry_cnt[c] - 40'd1;
				else begin
					retry_go_o[c]  <= 1'b1; // [R13]
					retry_cnt[c] <= l11_ms_cyc(retry_iv[c]);
				end
			end
		end
	end
endmodule : ptc_bank

// ### sim/ptc_bank_assertions.sv
// checker: command answers and pin timing of the bank
`timescale 1ns/1ps
module ptc_bank_assertions (
	input wire logic        ref_clk_i, reset_i, cmd_valid_i, cmd_write_i,
	input wire logic [7:0]  cmd_code_i,
	input wire logic [15:0] cmd_rdata_o, fault_src_i,
	input wire logic        cmd_ack_o, cmd_err_o, fault_pin_i,
	input wire logic        fault_pin_oe_o, ext_fault_seen_o,
	input wire logic [1:0]  restart_req_i, run_pin_oe_o,
	input wire logic [6:0]  bus_address_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	chk_ack_follows: assert property (
		cmd_valid_i |=> cmd_ack_o) else $error("ack missing");
	chk_no_stray: assert property (
		!cmd_valid_i |=> !cmd_ack_o && !cmd_err_o) else $error("stray ack");
	chk_rev_fixed: assert property (
		cmd_valid_i && !cmd_write_i && cmd_code_i == 8'h98
		|=> cmd_rdata_o == 16'h0022 && !cmd_err_o) else $error("bad rev");
	chk_ro_refused: assert property (
		cmd_valid_i && cmd_write_i && cmd_code_i == 8'hdd |=> cmd_err_o)
		else $error("ro write taken");
	chk_fault_quiet: assert property (
		fault_src_i == 0 |=> fault_pin_oe_o) else $error("pin pulled");
	chk_ext_seen: assert property (
		!fault_pin_i && fault_pin_oe_o |=> ext_fault_seen_o)
		else $error("low pin missed");
	chk_restart_low: assert property (
		restart_req_i[0] |=> !run_pin_oe_o[0]) else $error("run free");
	chk_addr_default: assert property (
		$fell(reset_i) |-> bus_address_o == 7'h4f) else $error("bad addr");
endmodule : ptc_bank_assertions

// ### sim/ptc_host.sv
// host model: one command at a time on the bank's command port
`timescale 1ns/1ps
module ptc_host (
	input  wire logic        clk_i, ack_i, err_i,
	input  wire logic [15:0] rdata_i,
	output logic             valid_o = 0, write_o = 0, page_o = 0,
	output logic [7:0]       code_o = 0,
	output logic [15:0]      wdata_o = 0
);
	// returns {ack, err, data}; codes and words pass as given
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic p, output logic [17:0] r);
		@(posedge clk_i);
		#1;
		{valid_o, write_o, code_o, wdata_o, page_o} = {1'b1, w, c, d, p};
		@(posedge clk_i);
		#1;
		valid_o = 0;
		// released lines change so a stale value is never read as valid
		wdata_o = ~d;
		code_o = ~c;
		r = {ack_i, err_i, rdata_i};
	endtask : xfer
endmodule : ptc_host

// ### sim/test_power_telemetry_command_bank.sv
// testbench: command bank under a host model with random telemetry
`timescale 1ns/1ps
module test_power_telemetry_command_bank;
	logic ref_clk_i = 0, reset_i = 1, bg = 1, gv = 0, ext_n = 1;
	logic [1:0] mv = 0, rreq = 0, rmode = 0;
	logic [31:0] vo = 0, io = 0, te = 0, fr = 0, po = 0, pi = 0;
	logic [15:0] vin = 0, iin = 0, tdie = 0, fsrc = 0, x0, x1, pv, pw;
	logic [17:0] r;
	wire [15:0] rdata, wdata, tgain;
	wire [7:0] code, act, adc;
	wire [6:0] addr;
	wire [1:0] ro, roe, rgo;
	wire ack, err, valid, wr, pg, fo, foe, seen, busy;
	wire fpin = foe & ext_n;
	int failures = 0, n_checks = 0, seed = 43293;
	logic [7:0] dc[15] = '{8'h98, 8'ha5, 8'hac, 8'hd2, 8'hd3, 8'hd4,
		8'hd5, 8'hd8, 8'hdb, 8'hdc, 8'he6, 8'he8, 8'hb3, 8'hb4, 8'hd0};
	logic [15:0] dv[15] = '{16'h22, 16'h5b33, 16'h5, 16'h6993, 16'hae,
		16'hc7, 16'hc0, 16'h0, 16'hfabc, 16'hfbe8, 16'h4f, 16'hca80,
		16'h0, 16'h0, 16'h1d};
	logic [7:0] pc[7] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hb3, 8'hdb, 8'hdc};
	logic [7:0] kc[4] = '{8'hd7, 8'hde, 8'hdf, 8'he1};
	ptc_bank #(.CHANNELS(2)) DUT (.ref_clk_i, .reset_i, .cmd_valid_i(valid),
		.cmd_write_i(wr), .cmd_code_i(code), .cmd_wdata_i(wdata),
		.cmd_page_i(pg), .cmd_rdata_o(rdata), .cmd_ack_o(ack),
		.cmd_err_o(err), .meas_valid_i(mv), .meas_vout_i(vo),
		.meas_iout_i(io), .meas_text_i(te), .meas_freq_i(fr),
		.meas_pout_i(po), .meas_pin_i(pi), .meas_gvalid_i(gv),
		.meas_vin_i(vin), .meas_iin_i(iin), .meas_tdie_i(tdie),
		.fault_pin_i(fpin), .fault_src_i(fsrc), .fault_pin_o(fo),
		.fault_pin_oe_o(foe), .run_pin_o(ro), .run_pin_oe_o(roe),
		.restart_req_i(rreq), .retry_mode_i(rmode), .retry_go_o(rgo),
		.ext_fault_action_o(act), .ext_fault_seen_o(seen),
		.fast_adc_select_o(adc), .bus_address_o(addr),
		.temp_for_gain_o(tgain), .nvm_busy_o(busy));
	ptc_host host (.clk_i(ref_clk_i), .ack_i(ack), .err_i(err),
		.rdata_i(rdata), .valid_o(valid), .write_o(wr), .page_o(pg),
		.code_o(code), .wdata_o(wdata));
	initial forever #2.5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) if (bg) begin
		#1;
		{mv, gv, ext_n, rreq, rmode} = 8'($random(seed));
		{vo, io, te} = {$random(seed), $random(seed), $random(seed)};
		{fr, po, pi} = {$random(seed), $random(seed), $random(seed)};
		{vin, iin, tdie, fsrc} = {$random(seed), $random(seed)};
	end
	function automatic logic [15:0] msk(input logic [7:0] c);
		return (c inside {8'hd3, 8'hd4, 8'hd5}) ? 16'h00ff : 16'hffff;
	endfunction : msk
	task automatic chk(input logic [17:0] got, exp, input string m);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s %h %h", $time, m, got, exp);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	initial begin
		repeat (90000) @(posedge ref_clk_i);
		failures++;
		stop_test();
	end
	initial begin
		repeat (20) @(posedge ref_clk_i);
		#1 reset_i = 0;
		foreach (dc[i]) for (int p = 0; p < 2; p++) begin
			host.xfer(0, dc[i], 0, 1'(p), r);
			chk(r, {2'b10, dv[i]}, "default");
		end
		$display("defaults done");
		foreach (pc[i]) begin
			x0 = 16'($random(seed)) & msk(pc[i]);
			x1 = 16'($random(seed)) & msk(pc[i]);
			host.xfer(1, pc[i], x0, 0, r);
			host.xfer(1, pc[i], x1, 1, r);
			host.xfer(0, pc[i], 0, 0, r);
			chk(r, {2'b10, x0}, "page 0");
			host.xfer(0, pc[i], 0, 1, r);
			chk(r, {2'b10, x1}, "page 1");
		end
		host.xfer(1, 8'hdd, x0, 0, r);
		chk({r[17:16], 16'h0}, 18'h30000, "ro write");
		host.xfer(1, 8'hb4, x0, 0, r);
		host.xfer(1, 8'h15, 0, 0, r);
		chk({17'h0, busy}, 18'h1, "store busy");
		host.xfer(1, 8'hb4, ~x0, 0, r);
		host.xfer(1, 8'h16, 0, 0, r);
		host.xfer(0, 8'hb4, 0, 0, r);
		chk(r, {2'b10, x0}, "restore");
		host.xfer(1, 8'hd5, x1, 0, r);
		host.xfer(1, 8'hd8, {8'h0, x1[7:0]}, 0, r);
		host.xfer(1, 8'he6, {9'h0, x0[6:0]}, 0, r);
		@(posedge ref_clk_i) #1;
		chk({10'h0, act}, {10'h0, x1[7:0]}, "action");
		chk({10'h0, adc}, {10'h0, x1[7:0]}, "adc");
		chk({11'h0, addr}, {11'h0, x0[6:0]}, "address");
		$display("registers done");
		bg = 0;
		@(posedge ref_clk_i);
		#1 {mv, gv, rreq, rmode, fsrc, ext_n} = 0;
		host.xfer(1, 8'he3, 0, 0, r);
		for (int k = 0; k < 12; k++) begin
			@(posedge ref_clk_i);
			#1;
			x0 = 16'($random(seed));
			x1 = {5'h1a, x0[10:0]};
			vo[15:0] = x0;
			{io[15:0], te[15:0], vin, iin} = {4{x1}};
			{mv, gv} = 3'b011;
			if (k == 0 || x0 > pv) pv = x0;
			if (k == 0 || $signed(x1[10:0]) > $signed(pw[10:0])) pw = x1;
			@(posedge ref_clk_i);
			#1 {mv, gv} = 0;
		end
		host.xfer(0, 8'hdd, 0, 0, r);
		chk(r, {2'b10, pv}, "vout peak");
		foreach (kc[i]) begin
			host.xfer(0, kc[i], 0, 0, r);
			chk(r, {2'b10, pw}, "peak");
		end
		chk({2'b0, tgain}, {2'b0, x1}, "gain temp");
		$display("peaks done");
		ext_n = 1;
		fsrc = 16'h0010;
		host.xfer(1, 8'hd2, 0, 1, r);
		host.xfer(1, 8'hd2, 0, 0, r);
		@(posedge ref_clk_i);
		#1 chk({17'h0, foe}, 18'h1, "unrouted");
		host.xfer(1, 8'hd2, fsrc, 0, r);
		@(posedge ref_clk_i);
		#1 chk({17'h0, foe}, 18'h0, "routed");
		host.xfer(1, 8'hdc, 16'h8001, 0, r);
		rreq = 1;
		@(posedge ref_clk_i);
		#1 rreq = 0;
		chk({17'h0, roe[0]}, 18'h0, "run hold");
		repeat (4) @(posedge ref_clk_i);
		#1 chk({17'h0, roe[0]}, 18'h1, "run freed");
		host.xfer(1, 8'hdb, 16'h8001, 0, r);
		@(posedge ref_clk_i) #1 rmode = 1;
		for (int k = 0; k < 100 && rgo[0] !== 1'b1; k++)
			@(posedge ref_clk_i) #1;
		chk({17'h0, rgo[0]}, 18'h1, "retry");
		$display("pins done");
		bg = 1;
		repeat (200) @(posedge ref_clk_i);
		stop_test();
	end
endmodule : test_power_telemetry_command_bank
bind ptc_bank ptc_bank_assertions chk (.*);
